// ---- core/gpfs_top.sv ----
// Second pin control register, function multiplexer and interrupt source logic.
// Assumes synchronous pin input, timeout tick and status inputs from the codec core.
// Behaviour
// [R1] Edge mode 0: single edge, rising if polarity 0, falling if 1.
// [R2] Edge mode 1: interrupt on both edges regardless of polarity.
// [R3] Polarity bit 10 inverts every selected input or output function.
// [R4] Writing level bit 5 sets the logic output level.
// [R5] Reading level bit returns the present input level for inputs.
// [R6] With polarity set, level bit is the complement of the pin.
// [R7] Function chosen by 4-bit field at bits 3:0.
// [R8] Code 0000: logic input, level-triggered interrupt.
// [R9] Code 0001: edge input, edge interrupt; timeout clock must be enabled.
// [R10] Code 0010: pin drives the divided clock output.
// [R11] Code 0011: pin drives the interrupt request output.
// [R12] Code 0111: pin drives overtemperature status.
// [R13] Code 1001: pin drives the digital microphone clock.
// [R14] Code 1010: logic output following the level bit.
// [R15] Code 1011: pin drives regulator undervoltage status.
// [R16] Interrupt inputs are debounced before the interrupt controller.
// [R17] Software sets direction bit 15 to match function; default input.
// [R18] Bits 14:13 select resistor: none, pull-down, pull-up, reserved.
// [R19] Debounce is clocked by the timeout clock.
// [R20] Reserved codes leave the pin with no active output function.
// [R21] After reset edge, polarity, level read zero; function is logic input. The level bit here reads the pulled-up pin, 1.
//
// Local design decisions: the register offsets and the address-and-strobe port.
module gpfs_top
  import gpfs_pkg::*;
#(
  parameter int DB_W = 8
)(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             pull_up_en,
  output logic             pull_down_en,
  input  wire logic        timeout_clock_tick,
  input  wire logic        timeout_clock_enable,
  input  wire logic        divided_clock_output,
  input  wire logic        irq_request,
  input  wire logic        overtemperature_status,
  input  wire logic        regulator_undervoltage_status,
  input  wire logic        digital_mic_clock,
  output logic             pin_irq_level,
  output logic             pin_irq_edge
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            dir;
    logic [1:0]      pull;
    logic            edge_mode;
    logic            pol;
    logic            lvl;
    logic [3:0]      fn;
    logic [DB_W-1:0] settle;
    logic [15:0]     rdata;
    logic            pin_out;
    logic            pin_oe_n;
    logic            pu;
    logic            pd;
    logic            prev_clean;
    logic            irq_level;
    logic            irq_edge;
  } gpfs_state_t;

  gpfs_state_t st;
  gpfs_state_t next_st;
  logic        clean_in;

  // Codes that make the pin an input function
  function automatic logic gpfs_is_input(input logic [3:0] fn);
    gpfs_is_input = (fn == GPFS_FN_LOGIC_IN) || (fn == GPFS_FN_EDGE_IN);
  endfunction : gpfs_is_input

  // Whether a function code has an output function; reserved codes give none
  function automatic logic gpfs_out_valid(input logic [3:0] fn);
    unique case (fn)
      GPFS_FN_DIVIDED_CLOCK_OUTPUT, GPFS_FN_IRQ, GPFS_FN_TEMP, GPFS_FN_DMIC_CLK,
      GPFS_FN_LOGIC_OUT, GPFS_FN_UV: gpfs_out_valid = 1'b1;
      default:                       gpfs_out_valid = 1'b0;
    endcase
  endfunction : gpfs_out_valid

  // ----------------------------------------------------------------
  // Debounce of the pin input
  // ----------------------------------------------------------------
  // Gating the tick leaves the filter frozen while the timeout clock is off
  gpfs_debounce #(
    .CNT_W (DB_W)
  ) u_debounce (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (timeout_clock_tick & timeout_clock_enable), // R19 R9
    .settle  (st.settle),
    .raw     (pin_in),
    .clean   (clean_in)                                   // R16
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic raw_drive;
  logic lvl_view;
  logic sense_now;
  logic sense_prev;

  always_comb
  begin
    next_st = st;

    // Register writes
    if (reg_wr && reg_addr == GPFS_ADDR_CTRL)
    begin
      next_st.dir       = reg_wdata[GPFS_BIT_DIR];                  // R17
      next_st.pull      = reg_wdata[GPFS_BIT_PULL_HI:GPFS_BIT_PULL_LO];
      next_st.edge_mode = reg_wdata[GPFS_BIT_EDGE];
      next_st.pol       = reg_wdata[GPFS_BIT_POL];
      next_st.lvl       = reg_wdata[GPFS_BIT_LVL];                  // R4
      next_st.fn        = reg_wdata[GPFS_BIT_FN_HI:GPFS_BIT_FN_LO]; // R7
    end
    else if (reg_wr && reg_addr == GPFS_ADDR_DEBOUNCE)
    begin
      next_st.settle = reg_wdata[DB_W-1:0];
    end

    // Function multiplexer, polarity applied last
    unique case (st.fn)
      GPFS_FN_DIVIDED_CLOCK_OUTPUT:    raw_drive = divided_clock_output;          // R10
      GPFS_FN_IRQ:       raw_drive = irq_request;                   // R11
      GPFS_FN_TEMP:      raw_drive = overtemperature_status;        // R12
      GPFS_FN_DMIC_CLK:  raw_drive = digital_mic_clock;             // R13
      GPFS_FN_LOGIC_OUT: raw_drive = st.lvl;                        // R14
      GPFS_FN_UV:        raw_drive = regulator_undervoltage_status; // R15
      default:           raw_drive = 1'b0;
    endcase
    next_st.pin_out  = raw_drive ^ st.pol;                          // R3 R6
    // Drive only when the function is an output and software agrees
    next_st.pin_oe_n = !(gpfs_out_valid(st.fn) && !st.dir);         // R20 R17

    next_st.pu = (st.pull == GPFS_PULL_UP);                         // R18
    next_st.pd = (st.pull == GPFS_PULL_DOWN);                       // R18

    // Level bit view: pin level seen through polarity for inputs
    lvl_view = gpfs_is_input(st.fn) ? (pin_in ^ st.pol) : st.lvl;   // R5 R6

    // Interrupt sources from the filtered input
    sense_now  = clean_in ^ st.pol;                                 // R3
    sense_prev = st.prev_clean ^ st.pol;
    next_st.prev_clean = clean_in;
    next_st.irq_level  = (st.fn == GPFS_FN_LOGIC_IN) && sense_now;  // R8
    next_st.irq_edge   = 1'b0;
    if (st.fn == GPFS_FN_EDGE_IN && clean_in != st.prev_clean)      // R9
    begin
      if (st.edge_mode)
      begin
        next_st.irq_edge = 1'b1;                                    // R2
      end
      else
      begin
        next_st.irq_edge = sense_now && !sense_prev;                // R1
      end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    next_st.rdata = 16'h0000;
    if (reg_rd && reg_addr == GPFS_ADDR_CTRL)
    begin
      next_st.rdata[GPFS_BIT_DIR]                   = st.dir;
      next_st.rdata[GPFS_BIT_PULL_HI:GPFS_BIT_PULL_LO] = st.pull;
      next_st.rdata[GPFS_BIT_EDGE]                  = st.edge_mode;
      next_st.rdata[GPFS_BIT_POL]                   = st.pol;
      next_st.rdata[GPFS_BIT_LVL]                   = lvl_view;
      next_st.rdata[GPFS_BIT_FN_HI:GPFS_BIT_FN_LO]  = st.fn;
    end
    else if (reg_rd && reg_addr == GPFS_ADDR_DEBOUNCE)
    begin
      next_st.rdata[DB_W-1:0] = st.settle;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.dir        <= GPFS_RST_DIR;
      st.pull       <= GPFS_RST_PULL;
      st.edge_mode  <= GPFS_RST_EDGE;    // R21
      st.pol        <= GPFS_RST_POL;     // R21
      st.lvl        <= GPFS_RST_LVL;     // R21
      st.fn         <= GPFS_FN_LOGIC_IN; // R21
      st.settle     <= GPFS_RST_DEBOUNCE[DB_W-1:0];
      st.pin_oe_n   <= 1'b1;
      st.pu         <= 1'b1;
      st.prev_clean <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata     = st.rdata;
  assign pin_out       = st.pin_out;
  assign pin_oe_n      = st.pin_oe_n;
  assign pull_up_en    = st.pu;
  assign pull_down_en  = st.pd;
  assign pin_irq_level = st.irq_level;
  assign pin_irq_edge  = st.irq_edge;

endmodule : gpfs_top

// ---- core/gpfs_pkg.sv ----
// Package for the second-pin function select block: field layout, codes, reset values.
// Assumes a 16-bit control register reached over a plain strobe port.
package gpfs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] GPFS_ADDR_CTRL      = 4'h0;
  localparam logic [3:0] GPFS_ADDR_DEBOUNCE  = 4'h1;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int GPFS_BIT_DIR      = 15;
  localparam int GPFS_BIT_PULL_HI  = 14;
  localparam int GPFS_BIT_PULL_LO  = 13;
  localparam int GPFS_BIT_EDGE     = 12;
  localparam int GPFS_BIT_POL      = 10;
  localparam int GPFS_BIT_LVL      = 5;
  localparam int GPFS_BIT_FN_HI    = 3;
  localparam int GPFS_BIT_FN_LO    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       GPFS_RST_DIR      = 1'b1;
  localparam logic [1:0] GPFS_RST_PULL     = 2'h2;
  localparam logic       GPFS_RST_EDGE     = 1'b0;
  localparam logic       GPFS_RST_POL      = 1'b0;
  localparam logic       GPFS_RST_LVL      = 1'b0;
  localparam logic [7:0] GPFS_RST_DEBOUNCE = 8'h04;

  // ----------------------------------------------------------------
  // Function codes and resistor select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] GPFS_FN_LOGIC_IN   = 4'h0;
  localparam logic [3:0] GPFS_FN_EDGE_IN    = 4'h1;
  localparam logic [3:0] GPFS_FN_DIVIDED_CLOCK_OUTPUT     = 4'h2;
  localparam logic [3:0] GPFS_FN_IRQ        = 4'h3;
  localparam logic [3:0] GPFS_FN_TEMP       = 4'h7;
  localparam logic [3:0] GPFS_FN_DMIC_CLK   = 4'h9;
  localparam logic [3:0] GPFS_FN_LOGIC_OUT  = 4'ha;
  localparam logic [3:0] GPFS_FN_UV         = 4'hb;

  localparam logic [1:0] GPFS_PULL_NONE     = 2'h0;
  localparam logic [1:0] GPFS_PULL_DOWN     = 2'h1;
  localparam logic [1:0] GPFS_PULL_UP       = 2'h2;

endpackage : gpfs_pkg

// ---- core/gpfs_debounce.sv ----
// Debounce filter for one pin input, stepped by timeout clock ticks.
// Assumes the tick is a one-cycle pulse synchronous to ref_clk.
module gpfs_debounce
  import gpfs_pkg::*;
#(
  parameter int CNT_W = 8
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] settle,
  input  wire logic             raw,
  output logic                  clean
);

  typedef struct packed {
    logic             clean;
    logic [CNT_W-1:0] cnt;
  } gpfs_db_state_t;

  gpfs_db_state_t st;
  gpfs_db_state_t next_st;

  // Input must disagree with the filtered value for settle + 1 ticks in a row
  always_comb
  begin
    next_st = st;
    if (raw == st.clean)
    begin
      next_st.cnt = '0;
    end
    else if (tick)
    begin
      if (st.cnt >= settle)
      begin
        next_st.clean = raw;
        next_st.cnt   = '0;
      end
      else
      begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Filter starts at the pulled-up idle level, so release brings no false edge
      st.clean <= 1'b1;
      st.cnt   <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign clean = st.clean;

endmodule : gpfs_debounce

// ---- sim/gpfs_checker.sv ----
// Port-level checker for the second pin block.
// Assumes it is bound to every gpfs_top instance.
module gpfs_checker
  import gpfs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        pin_oe_n,
  input wire logic        pull_up_en,
  input wire logic        pull_down_en,
  input wire logic        timeout_clock_tick,
  input wire logic        timeout_clock_enable,
  input wire logic        pin_irq_level,
  input wire logic        pin_irq_edge
);
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic tk;
  // A write may move the edge reference, so it counts as a cause too
  assign tk = timeout_clock_tick & timeout_clock_enable;
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_unmapped;
    reg_rd && reg_addr > 4'h1 |=> reg_rdata == 16'h0; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_fields;
    reg_rd && reg_addr == GPFS_ADDR_CTRL |=> reg_rdata[11] == 1'b0 && reg_rdata[4] == 1'b0
      && reg_rdata[9:6] == 4'h0; endproperty
  a_rd_fields: assert property (p_rd_fields) else $error("unused control bits set");
  property p_edge_pulse;
    pin_irq_edge |=> !pin_irq_edge; endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse too long");
  property p_edge_cause;
    pin_irq_edge |-> $past(tk) || $past(tk, 2) || $past(tk, 3) || $past(reg_wr, 2); endproperty
  a_edge_cause: assert property (p_edge_cause) else $error("edge without tick");
  property p_irq_excl;
    !(pin_irq_level && pin_irq_edge); endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("level and edge together");
  property p_pull_excl;
    !(pull_up_en && pull_down_en); endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both resistors on");
  property p_oe_cause;
    $changed(pin_oe_n) |-> $past(reg_wr, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive changed without write");
  property p_pull_cause;
    $changed(pull_up_en) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_pull_cause: assert property (p_pull_cause) else $error("pull changed without write");
endmodule : gpfs_checker

bind gpfs_top gpfs_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_oe_n(pin_oe_n),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .timeout_clock_tick(timeout_clock_tick),
  .timeout_clock_enable(timeout_clock_enable), .pin_irq_level(pin_irq_level),
  .pin_irq_edge(pin_irq_edge));

// ---- sim/gpfs_pin_partner.sv ----
// Push button to ground on the second pin, plus the pad resistors.
// Assumes pin_in is sampled on ref_clk; a floating pin toggles so no stale level is read.
module gpfs_pin_partner
(
  input  wire logic ref_clk,
  input  wire logic press,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  output logic      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_in = 1'b1;
  always @(posedge ref_clk)
  begin
    if (!pin_oe_n)
      pin_in <= pin_out;
    else if (press)
      pin_in <= 1'b0;
    else if (pull_up_en)
      pin_in <= 1'b1;
    else if (pull_down_en)
      pin_in <= 1'b0;
    else
      pin_in <= ~pin_in;
  end
endmodule : gpfs_pin_partner

// ---- sim/gpfs_bench.sv ----
// Self-checking bench for gpfs_top: register port, multiplexer, pin interrupts.
// Assumes the pin partner model and the bound checker.
module gpfs_bench
  import gpfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en, irq_level, irq_edge;
  logic        tick = 1'b0;
  logic        tk_en = 1'b0;
  logic        press = 1'b0;
  logic [4:0]  src = 5'h0;
  logic [1:0]  tcnt = 2'h0;
  int          bad_count = 0;
  int          n_checks = 0;

  gpfs_top DUT (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_in, .pin_out, .pin_oe_n, .pull_up_en, .pull_down_en, .timeout_clock_tick(tick),
    .timeout_clock_enable(tk_en), .divided_clock_output(src[0]), .irq_request(src[1]),
    .overtemperature_status(src[2]), .digital_mic_clock(src[3]),
    .regulator_undervoltage_status(src[4]), .pin_irq_level(irq_level), .pin_irq_edge(irq_edge));
  gpfs_pin_partner u_pin (.ref_clk, .press, .pin_out, .pin_oe_n, .pull_up_en, .pull_down_en,
    .pin_in);

  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask : rd
  task automatic edges(input logic p, output int n);
    press <= p;
    n = 0;
    repeat (60)
    begin
      @(negedge ref_clk);
      if (irq_edge === 1'b1)
        n++;
    end
    @(posedge ref_clk);
  endtask : edges
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    logic [15:0] d;
    rd(GPFS_ADDR_CTRL, d);
    chk(d, 16'hc020, "control after reset");
    chk({pin_oe_n, pull_up_en, pull_down_en}, 3'b110, "pad after reset");
    rd(4'h7, d);
    chk(d, 16'h0, "unmapped read");
    wr(GPFS_ADDR_CTRL, 16'hffff);
    rd(GPFS_ADDR_CTRL, d);
    chk(d, 16'hf42f, "control fields");
    $display("reset test done");
  endtask : t_reset
  task automatic t_mux;
    logic [3:0] fns [6] = '{GPFS_FN_DIVIDED_CLOCK_OUTPUT, GPFS_FN_IRQ, GPFS_FN_TEMP, GPFS_FN_DMIC_CLK,
      GPFS_FN_UV, GPFS_FN_LOGIC_OUT};
    for (int v = 0; v < 4; v++)
    begin
      src <= {5{v[0]}};
      for (int i = 0; i < 6; i++)
      begin
        wr(GPFS_ADDR_CTRL, {5'h0, v[1], 4'h0, v[0], 1'b0, fns[i]});
        chk({pin_oe_n, pin_out}, {1'b0, v[0] ^ v[1]}, "mux out");
      end
    end
    for (int f = 0; f < 16; f++)
      if (f inside {4, 5, 6, 8, [12:15]})
      begin
        wr(GPFS_ADDR_CTRL, 16'(f));
        chk(pin_oe_n, 1'b1, "reserved code drives");
      end
    wr(GPFS_ADDR_CTRL, 16'h802a);
    chk(pin_oe_n, 1'b1, "input direction drives");
    $display("mux test done");
  endtask : t_mux
  task automatic t_level;
    logic [15:0] d;
    for (int v = 0; v < 4; v++)
    begin
      wr(GPFS_ADDR_CTRL, 16'hc000 | (16'(v[1]) << 10));
      press <= v[0];
      repeat (2) @(posedge ref_clk);
      rd(GPFS_ADDR_CTRL, d);
      chk(d[5], !v[0] ^ v[1], "level read");
    end
    press <= 1'b0;
    wr(GPFS_ADDR_CTRL, 16'h8000);
    chk({pull_up_en, pull_down_en}, 2'b00, "no resistor");
    wr(GPFS_ADDR_CTRL, 16'ha000);
    chk({pull_up_en, pull_down_en}, 2'b01, "pull-down");
    $display("level test done");
  endtask : t_level
  task automatic t_irq;
    int n;
    tk_en <= 1'b1;
    // Short settle keeps each window small
    wr(GPFS_ADDR_DEBOUNCE, 16'h0002);
    wr(GPFS_ADDR_CTRL, 16'hc000);
    repeat (40) @(posedge ref_clk);
    chk(irq_level, 1'b1, "level irq high");
    wr(GPFS_ADDR_CTRL, 16'hc400);
    repeat (40) @(posedge ref_clk);
    chk(irq_level, 1'b0, "level irq inverted");
    wr(GPFS_ADDR_CTRL, 16'hc001);
    edges(1'b1, n);
    chk(n, 0, "falling, rising mode");
    edges(1'b0, n);
    chk(n, 1, "rising, rising mode");
    wr(GPFS_ADDR_CTRL, 16'hc401);
    edges(1'b1, n);
    chk(n, 1, "falling, inverted");
    edges(1'b0, n);
    chk(n, 0, "rising, inverted");
    wr(GPFS_ADDR_CTRL, 16'hd401);
    edges(1'b1, n);
    chk(n, 1, "both edges, fall");
    edges(1'b0, n);
    chk(n, 1, "both edges, rise");
    press <= 1'b1;
    @(posedge ref_clk);
    edges(1'b0, n);
    chk(n, 0, "glitch");
    tk_en <= 1'b0;
    edges(1'b1, n);
    chk(n, 0, "frozen without ticks");
    edges(1'b0, n);
    tk_en <= 1'b1;
    repeat (40) @(posedge ref_clk);
    $display("interrupt test done");
  endtask : t_irq

  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_mux;
    t_level;
    t_irq;
    finish_test;
  end
endmodule : gpfs_bench
